/* File: uts_serial_if.sv */
/*
 * Pin-level serial link between the USB protocol engine and an external
 * full/low-speed transceiver, in any of four wiring modes.
 * Assumes all pin inputs are synchronous to mclk_i and that the pad ring
 * resolves each shared pin from its output enable.
 */
`default_nettype none

// Functional notes
// R1: Transmit enable is active low; low only while sending, high while receiving.
// R2: Single-ended-zero unidirectional: data pin carries data, zero pin carries SE0; outputs only.
// R3: Transceiver gives buffered D+ and D- on dedicated inputs while enable is high.
// R4: Transceiver gives differential receive data on its input; used as serial data.
// R5: Plus/minus bidirectional: drive both pins while sending, release and sample otherwise.
// R6: Plus/minus unidirectional: drive output pins while sending, read separate inputs otherwise.
// R7: Interface works in exactly one of four wiring modes.
// R8: Mode comes from a static input and changes only while not transmitting.
module uts_serial_if (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              nrst_i,
    // Configuration
    input  wire uts_pkg::uts_mode_t mode_i,
    // Protocol engine side
    input  wire uts_pkg::uts_tx_t  tx_i,
    output logic                   tx_busy_o,
    output uts_pkg::uts_rx_t       rx_o,
    output uts_pkg::uts_mode_t     mode_o,
    // Transceiver pins
    output logic                   tx_enable_n_o,
    input  wire logic              line_data_plus_pin_i,
    output logic                   line_data_plus_pin_o,
    output logic                   line_data_plus_pin_oe_o,
    input  wire logic              zero_minus_pin_i,
    output logic                   zero_minus_pin_o,
    output logic                   zero_minus_pin_oe_o,
    input  wire logic              rx_plus_input_i,
    input  wire logic              rx_minus_input_i,
    input  wire logic              diff_receive_input_i
);
    import uts_pkg::*;

    uts_mode_t mode_q,    mode_d;
    logic      txen_n_q,  txen_n_d;
    logic      plus_q,    plus_d;
    logic      minus_q,   minus_d;
    uts_rx_t   rx_q,      rx_d;

    // Mode and transmit control
    always_comb begin
        mode_d   = mode_q;
        txen_n_d = ~tx_i.active;                                   // R1
        if (!tx_i.active && txen_n_q) begin
            mode_d = mode_i;                                       // R8
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q   <= MODE_RST;
            txen_n_q <= TXEN_N_RST;
        end else begin
            mode_q   <= mode_d;
            txen_n_q <= txen_n_d;
        end
    end

    // Transmit line encoding
    always_comb begin
        plus_d  = PLUS_IDLE;
        minus_d = MINUS_IDLE;
        if (tx_i.active) begin
            unique case (mode_q)
                UTS_MODE_SE0_BIDIR,
                UTS_MODE_SE0_UNI: begin
                    plus_d  = tx_i.dp;                             // R2
                    minus_d = uts_is_se0(tx_i.dp, tx_i.dm);        // R2
                end
                UTS_MODE_PM_BIDIR,
                UTS_MODE_PM_UNI: begin
                    plus_d  = tx_i.dp;                             // R5 R6
                    minus_d = tx_i.dm;                             // R5 R6
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            plus_q  <= PLUS_IDLE;
            minus_q <= MINUS_IDLE;
        end else begin
            plus_q  <= plus_d;
            minus_q <= minus_d;
        end
    end

    // Receive decoding, only while the link is turned round to receive
    always_comb begin
        rx_d       = rx_q;
        rx_d.valid = txen_n_q;                                     // R1
        if (txen_n_q) begin
            unique case (mode_q)                                   // R7
                UTS_MODE_SE0_BIDIR: begin
                    rx_d.rcv = line_data_plus_pin_i;
                    rx_d.se0 = zero_minus_pin_i;
                    rx_d.dp  = ~zero_minus_pin_i & line_data_plus_pin_i;
                    rx_d.dm  = ~zero_minus_pin_i & ~line_data_plus_pin_i;
                end
                UTS_MODE_PM_BIDIR: begin
                    rx_d.dp  = line_data_plus_pin_i;               // R5
                    rx_d.dm  = zero_minus_pin_i;                   // R5
                    rx_d.rcv = diff_receive_input_i;
                    rx_d.se0 = uts_is_se0(line_data_plus_pin_i, zero_minus_pin_i);
                end
                UTS_MODE_SE0_UNI,
                UTS_MODE_PM_UNI: begin
                    rx_d.dp  = rx_plus_input_i;                    // R3 R6
                    rx_d.dm  = rx_minus_input_i;                   // R3 R6
                    rx_d.rcv = diff_receive_input_i;               // R4
                    rx_d.se0 = uts_is_se0(rx_plus_input_i, rx_minus_input_i);
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_q <= RX_RST;
        end else begin
            rx_q <= rx_d;
        end
    end

    // Shared pins release only in bidirectional modes while receiving
    assign line_data_plus_pin_oe_o = uts_is_uni(mode_q) | ~txen_n_q;  // R2 R5 R6
    assign zero_minus_pin_oe_o     = uts_is_uni(mode_q) | ~txen_n_q;  // R2 R5 R6
    assign line_data_plus_pin_o    = plus_q;
    assign zero_minus_pin_o        = minus_q;
    assign tx_enable_n_o           = txen_n_q;
    assign tx_busy_o               = ~txen_n_q;
    assign rx_o                    = rx_q;
    assign mode_o                  = mode_q;

    function automatic logic uts_is_se0_mode(input uts_mode_t m);
        return (m == UTS_MODE_SE0_BIDIR) || (m == UTS_MODE_SE0_UNI);
    endfunction

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_tx_start;
        !tx_i.active ##1 tx_i.active;
    endsequence

    sequence s_tx_stop;
        tx_i.active ##1 !tx_i.active;
    endsequence

    a_txen_on_start: assert property (                              // R1
        s_tx_start |=> !tx_enable_n_o && line_data_plus_pin_oe_o)
        else $error("transmit enable not low after transmit start");

    a_txen_on_stop: assert property (                               // R1
        s_tx_stop |=> tx_enable_n_o && rx_o.valid == 1'h0 ##1 rx_o.valid)
        else $error("transmit enable or receive valid wrong after stop");

    a_se0_uni_drive: assert property (                              // R2
        tx_i.active && mode_q == UTS_MODE_SE0_UNI |=>
            line_data_plus_pin_o == $past(tx_i.dp) &&
            zero_minus_pin_o == (!$past(tx_i.dp) && !$past(tx_i.dm)))
        else $error("data or zero pin wrong in single-ended-zero mode");

    a_uni_out_only: assert property (                               // R2
        uts_is_uni(mode_q) |-> line_data_plus_pin_oe_o && zero_minus_pin_oe_o)
        else $error("unidirectional pin released");

    a_uni_rx_levels: assert property (                              // R3
        tx_enable_n_o && uts_is_uni(mode_q) |=>
            rx_o.dp == $past(rx_plus_input_i) && rx_o.dm == $past(rx_minus_input_i))
        else $error("received levels not taken from dedicated inputs");

    a_rx_diff_data: assert property (                               // R4
        tx_enable_n_o && mode_q == UTS_MODE_SE0_UNI |=>
            rx_o.valid && rx_o.rcv == $past(diff_receive_input_i))
        else $error("differential receive data not taken");

    a_pm_drive: assert property (                                   // R5
        tx_i.active && !uts_is_se0_mode(mode_q) |=>
            line_data_plus_pin_o == $past(tx_i.dp) && zero_minus_pin_o == $past(tx_i.dm))
        else $error("plus or minus pin not driven with line state");

    a_pm_bidir_release: assert property (                           // R5
        mode_q == UTS_MODE_PM_BIDIR && tx_enable_n_o |->
            !line_data_plus_pin_oe_o && !zero_minus_pin_oe_o)
        else $error("bidirectional pins driven while receiving");

    a_pm_uni_rx: assert property (                                  // R6
        tx_enable_n_o && mode_q == UTS_MODE_PM_UNI |=>
            rx_o.se0 == (!$past(rx_plus_input_i) && !$past(rx_minus_input_i)))
        else $error("single-ended zero not detected from separate inputs");

    a_mode_stable: assert property (                                // R8
        !tx_enable_n_o || tx_i.active |=> $stable(mode_q))
        else $error("mode changed during transmission");

    a_se0_bidir_oe: assert property (                               // R7
        mode_q == UTS_MODE_SE0_BIDIR |->
            line_data_plus_pin_oe_o == !tx_enable_n_o)
        else $error("three-wire pin direction wrong");

    a_idle_levels: assert property (                                // R6
        !tx_i.active |=>
            line_data_plus_pin_o == PLUS_IDLE && zero_minus_pin_o == MINUS_IDLE)
        else $error("shared pins not at idle levels outside transmission");

    a_pm_bidir_rx: assert property (                                // R5
        tx_enable_n_o && mode_q == UTS_MODE_PM_BIDIR |=>
            rx_o.dp == $past(line_data_plus_pin_i) && rx_o.dm == $past(zero_minus_pin_i))
        else $error("received plus or minus not taken from shared pins");

    a_rx_hold: assert property (                                    // R1
        !tx_enable_n_o |=> !rx_o.valid && $stable(rx_o[3:0]))
        else $error("receive state sampled while transmitting");

endmodule // uts_serial_if

`default_nettype wire

/* File: uts_pkg.sv */
/*
 * Shared types and constants for the USB transceiver serial interface.
 * Assumes a single 40 MHz clock domain and an asynchronous active-low reset.
 */
`default_nettype none

package uts_pkg;

    // Transceiver interface wiring modes
    typedef enum logic [1:0] {
        UTS_MODE_SE0_BIDIR,
        UTS_MODE_SE0_UNI,
        UTS_MODE_PM_BIDIR,
        UTS_MODE_PM_UNI
    } uts_mode_t;

    // Line state requested by the protocol engine
    typedef struct packed {
        logic active;
        logic dp;
        logic dm;
    } uts_tx_t;

    // Received line state handed to the protocol engine
    typedef struct packed {
        logic valid;
        logic dp;
        logic dm;
        logic rcv;
        logic se0;
    } uts_rx_t;

    localparam uts_mode_t MODE_RST      = UTS_MODE_SE0_BIDIR;
    localparam logic      TXEN_N_RST    = 1'h1;
    localparam logic      PLUS_IDLE     = 1'h1;
    localparam logic      MINUS_IDLE    = 1'h0;
    localparam uts_rx_t   RX_RST        = '0;

    function automatic logic uts_is_se0(input logic dp, input logic dm);
        return ~dp & ~dm;
    endfunction

    function automatic logic uts_is_uni(input uts_mode_t m);
        return (m == UTS_MODE_SE0_UNI) || (m == UTS_MODE_PM_UNI);
    endfunction

endpackage

`default_nettype wire

/* File: uts_xcvr.sv */
/* Behavioural full-speed transceiver on the far side of the serial link.
   Assumes the bench supplies the cable state and resolves the shared pins. */
`default_nettype none
module uts_xcvr (
    // Clock, mode and enable
    input  wire logic               mclk_i,
    input  wire uts_pkg::uts_mode_t mode_i,
    input  wire logic               txen_n_i,
    // Cable line state
    input  wire logic               dp_i,
    input  wire logic               dm_i,
    // Plus pin, minus pin, rx plus, rx minus, diff receive
    output logic [4:0]              pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import uts_pkg::*;
    logic [4:0] held_q;
    logic       rcv_q;
    logic       rcv;
    logic       se0;
    assign se0 = ~dp_i & ~dm_i;
    // Receiver holds its last level through SE0
    assign rcv = se0 ? rcv_q : dp_i;
    // Released lines show the inverse of the last level
    assign pin_o = !txen_n_i ? ~held_q :
        (mode_i == UTS_MODE_SE0_BIDIR) ? {rcv, se0, dp_i, dm_i, rcv} :
        {dp_i, dm_i, dp_i, dm_i, rcv};
    always_ff @(posedge mclk_i) begin
        if (txen_n_i) begin
            held_q <= pin_o;
            rcv_q  <= rcv;
        end
    end
endmodule // uts_xcvr
`default_nettype wire

/* File: uts_serial_if_test.sv */
/* Self-checking bench for the transceiver serial interface.
   Assumes one 40 MHz clock; inputs change on the falling edge. */
`default_nettype none
module uts_serial_if_test;
    timeunit 1ns;
    timeprecision 100ps;
    import uts_pkg::*;
    logic       mclk_i = 1'b0;
    logic       nrst_i = 1'b1;
    uts_mode_t  mode_i = UTS_MODE_SE0_BIDIR;
    uts_tx_t    tx_i = '0;
    logic       dp = 1'b1;
    logic       dm = 1'b0;
    logic       rcv_exp = 1'b1;
    int         n_mismatch = 0;
    int         check_count = 0;
    logic       busy, txen_n, dp_o, dp_oe, zm_o, zm_oe;
    uts_rx_t    rx;
    uts_mode_t  mode_o;
    logic [4:0] pin;
    wire logic  dp_w = dp_oe ? dp_o : pin[4];
    wire logic  zm_w = zm_oe ? zm_o : pin[3];

    uts_serial_if u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .mode_i(mode_i), .tx_i(tx_i),
        .tx_busy_o(busy), .rx_o(rx), .mode_o(mode_o), .tx_enable_n_o(txen_n),
        .line_data_plus_pin_i(dp_w), .line_data_plus_pin_o(dp_o),
        .line_data_plus_pin_oe_o(dp_oe), .zero_minus_pin_i(zm_w), .zero_minus_pin_o(zm_o),
        .zero_minus_pin_oe_o(zm_oe), .rx_plus_input_i(pin[2]), .rx_minus_input_i(pin[1]),
        .diff_receive_input_i(pin[0]));
    uts_xcvr u_xcvr (.mclk_i(mclk_i), .mode_i(mode_o), .txen_n_i(txen_n), .dp_i(dp),
        .dm_i(dm), .pin_o(pin));

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic set_mode(input uts_mode_t m);
        @(negedge mclk_i);
        mode_i = m;
        @(negedge mclk_i);
        chk("mode", m, mode_o);
    endtask

    task automatic t_transmit(input uts_mode_t m);
        logic [1:0] st [3] = '{2'b10, 2'b01, 2'b00};
        logic [1:0] e;
        logic       uni;
        uni = m inside {UTS_MODE_SE0_UNI, UTS_MODE_PM_UNI};
        set_mode(m);
        for (int i = 0; i < 3; i++) begin
            tx_i = {1'b1, st[i]};
            @(negedge mclk_i);
            e = (m inside {UTS_MODE_SE0_BIDIR, UTS_MODE_SE0_UNI}) ?
                {st[i][1], st[i] == 2'b00} : st[i];
            chk("tx pins", {4'b0111, e}, {txen_n, busy, dp_oe, zm_oe, dp_w, zm_w});
        end
        tx_i = '0;
        @(negedge mclk_i);
        chk("tx idle", {2'b10, uni, uni, 2'b10}, {txen_n, busy, dp_oe, zm_oe, dp_o, zm_o});
    endtask

    task automatic t_receive(input uts_mode_t m);
        logic [1:0] st [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
        set_mode(m);
        for (int i = 0; i < 4; i++) begin
            {dp, dm} = st[i];
            rcv_exp = (st[i] == 2'b00) ? rcv_exp : st[i][1];
            @(negedge mclk_i);
            chk("rx", {1'b1, st[i], rcv_exp, st[i] == 2'b00}, rx);
        end
    endtask

    task automatic t_mode_lock();
        set_mode(UTS_MODE_PM_UNI);
        tx_i = 3'b110;
        @(negedge mclk_i);
        mode_i = UTS_MODE_SE0_BIDIR;
        repeat (3) @(negedge mclk_i);
        chk("mode held", UTS_MODE_PM_UNI, mode_o);
        chk("oe held", 2'b11, {dp_oe, zm_oe});
        tx_i = '0;
        @(negedge mclk_i);
        chk("mode still", UTS_MODE_PM_UNI, mode_o);
        @(negedge mclk_i);
        chk("mode after", UTS_MODE_SE0_BIDIR, mode_o);
    endtask

    initial begin
        #1 nrst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk("reset", {4'b1000, 2'b10}, {txen_n, busy, dp_oe, zm_oe, dp_o, zm_o});
        chk("reset rx", RX_RST, rx);
        nrst_i = 1'b1;
        for (int k = 0; k < 4; k++) begin
            t_transmit(uts_mode_t'(k));
            t_receive(uts_mode_t'(k));
        end
        t_mode_lock();
        end_of_test();
    end

    // Watchdog against a hung run
    initial begin
        repeat (2000) @(posedge mclk_i);
        n_mismatch++;
        end_of_test();
    end
endmodule // uts_serial_if_test
`default_nettype wire
